// ===== rtl/fetch_dispatch_pkg.sv
// constants, field layout and state type of the fetch and dispatch front end
// assumes one core clock and a synchronous active-low reset
package fetch_dispatch_pkg;
  // ==========================================================================
  // packet geometry
  localparam int SLOTS   = 8;
  localparam int INSTR_W = 32;
  localparam int PKT_W   = 256;
  localparam int UNITS   = 8;
  localparam int RF_REGS = 16;
  localparam int RF_ALL  = 32;
  // ==========================================================================
  // fetch addressing
  localparam logic [31:0] FETCH_RESET_ADDR = 32'h0000_0000;
  localparam logic [31:0] FETCH_STEP       = 32'h0000_0020;
  localparam logic [2:0]  LAST_SLOT        = 3'h7;
  // ==========================================================================
  // instruction fields
  localparam int CHAIN_BIT    = 0;
  localparam int UNIT_LSB     = 2;
  localparam int STORE_BIT    = 5;
  localparam int MEM_BIT      = 6;
  localparam int LONG_BIT     = 7;
  localparam int LONG_OFF_LSB = 8;
  localparam int CIRC_BIT     = 9;
  localparam int SIZE_LSB     = 10;
  localparam int XPATH_BIT    = 12;
  localparam int SRC1_LSB     = 13;
  localparam int SRC2_LSB     = 18;
  localparam int DST_LSB      = 23;
  localparam int Z_BIT        = 28;
  localparam int CREG_LSB     = 29;
  localparam logic [3:0] LONG_BASE_REG = 4'hf;
  // ==========================================================================
  // unit codes, side a is 0..3, side b is 4..7
  localparam logic [2:0] U_LOGIC_A = 3'h0;
  localparam logic [2:0] U_SHIFT_A = 3'h1;
  localparam logic [2:0] U_MUL_A   = 3'h2;
  localparam logic [2:0] U_ADDR_A  = 3'h3;
  localparam logic [1:0] U_ADDR    = 2'h3;
  // ==========================================================================
  // access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  typedef enum logic {ST_WAIT = 1'b0, ST_DISP = 1'b1} fetch_state_e;
endpackage : fetch_dispatch_pkg

// ===== rtl/vliw_fetch_packet_dispatch.sv
// fetch packet splitter, dispatcher, register files and address units
// assumes program memory answers a held request with a valid strobe
`timescale 1ns/10ps
module vliw_fetch_packet_dispatch #(
  parameter int CIRC_BITS = 8
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  // program memory
  output logic              o_fetch_req,
  output logic [31:0]       o_fetch_addr,
  input  wire logic         i_fetch_valid,
  input  wire logic [255:0] i_fetch_data,
  // functional unit issue, index 0..7 by unit code
  output logic [7:0]        o_unit_valid,
  output logic [7:0]        o_unit_exec,
  output logic [255:0]      o_unit_instr,
  output logic [255:0]      o_unit_opa,
  output logic [255:0]      o_unit_opb,
  // result writeback
  input  wire logic [7:0]   i_wb_en,
  input  wire logic [39:0]  i_wb_dst,
  input  wire logic [255:0] i_wb_data,
  // data memory, index 0 side a, 1 side b
  output logic [1:0]        o_mem_req,
  output logic [1:0]        o_mem_we,
  output logic [3:0]        o_mem_size,
  output logic [63:0]       o_mem_addr,
  output logic [63:0]       o_mem_wdata,
  // error flags, one cycle
  output logic              o_unit_clash,
  output logic              o_xpath_err,
  output logic              o_illegal
);
  // ==========================================================================
  // state
  fetch_dispatch_pkg::fetch_state_e state_r, state_nxt;
  logic [31:0]  pc_r, pc_nxt;
  logic [255:0] pkt_r, pkt_nxt;
  logic [2:0]   ptr_r, ptr_nxt;
  logic         req_r, req_nxt;
  logic [31:0]  rf_r [0:31];
  logic [31:0]  rf_nxt [0:31];
  logic [7:0]   valid_r, valid_nxt, exec_r, exec_nxt;
  logic [255:0] instr_r, instr_nxt, opa_r, opa_nxt, opb_r, opb_nxt;
  logic [1:0]   mreq_r, mreq_nxt, mwe_r, mwe_nxt;
  logic [3:0]   msize_r, msize_nxt;
  logic [63:0]  maddr_r, maddr_nxt, mwdata_r, mwdata_nxt;
  logic         clash_r, clash_nxt, xerr_r, xerr_nxt, ill_r, ill_nxt;
  logic [7:0]   grp_mask;
  logic [2:0]   end_slot;
  logic         found;
  logic [1:0]   xr_used, xw_used;
  logic         xerr_nxt_rd, xerr_nxt_wr;
  logic [31:0]  ins, base, off, sum, wb_word;
  logic [2:0]   u;
  logic         side, ex;
  logic [1:0]   sz;
  logic [4:0]   wdst;

  // ==========================================================================
  // helpers
  function automatic logic [4:0] cond_reg(input logic [2:0] creg);
    case (creg)
      3'h1:    cond_reg = 5'h01;
      3'h2:    cond_reg = 5'h02;
      3'h3:    cond_reg = 5'h10;
      3'h4:    cond_reg = 5'h11;
      3'h5:    cond_reg = 5'h12;
      default: cond_reg = 5'h00;
    endcase
  endfunction : cond_reg

  function automatic logic [31:0] fmt_store(input logic [31:0] d, input logic [1:0] s);
    case (s)
      fetch_dispatch_pkg::SZ_BYTE: fmt_store = {4{d[7:0]}};
      fetch_dispatch_pkg::SZ_HALF: fmt_store = {2{d[15:0]}};
      default:                     fmt_store = d;
    endcase
  endfunction : fmt_store

  // ==========================================================================
  // fetch and packet split
  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    pkt_nxt   = pkt_r;
    ptr_nxt   = ptr_r;
    req_nxt   = req_r;
    found     = 1'b0;
    end_slot  = fetch_dispatch_pkg::LAST_SLOT;
    grp_mask  = 8'h00;
    for (int i = 0; i < fetch_dispatch_pkg::SLOTS; i++) begin
      if (!found && (3'(i) >= ptr_r) &&
          (!pkt_r[i*32 + fetch_dispatch_pkg::CHAIN_BIT] || 3'(i) == fetch_dispatch_pkg::LAST_SLOT)) begin
        end_slot = 3'(i);
        found    = 1'b1;
      end
    end
    for (int i = 0; i < fetch_dispatch_pkg::SLOTS; i++) begin
      grp_mask[i] = (state_r == fetch_dispatch_pkg::ST_DISP) && (3'(i) >= ptr_r) && (3'(i) <= end_slot);
    end
    case (state_r)
      fetch_dispatch_pkg::ST_WAIT: begin
        req_nxt = 1'b1;
        if (req_r && i_fetch_valid) begin
          pkt_nxt   = i_fetch_data;
          pc_nxt    = pc_r + fetch_dispatch_pkg::FETCH_STEP;
          ptr_nxt   = 3'h0;
          req_nxt   = 1'b0;
          state_nxt = fetch_dispatch_pkg::ST_DISP;
        end
      end
      fetch_dispatch_pkg::ST_DISP: begin
        ptr_nxt = end_slot + 3'h1;
        if (end_slot == fetch_dispatch_pkg::LAST_SLOT) begin
          state_nxt = fetch_dispatch_pkg::ST_WAIT;
          req_nxt   = 1'b1;
        end
      end
      default: begin
        state_nxt = fetch_dispatch_pkg::ST_WAIT;
        req_nxt   = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // issue to units, operand read, address generation
  always_comb begin
    valid_nxt  = 8'h00;
    exec_nxt   = 8'h00;
    instr_nxt  = instr_r;
    opa_nxt    = opa_r;
    opb_nxt    = opb_r;
    mreq_nxt   = 2'h0;
    mwe_nxt    = 2'h0;
    msize_nxt  = msize_r;
    maddr_nxt  = maddr_r;
    mwdata_nxt = mwdata_r;
    clash_nxt  = 1'b0;
    ill_nxt    = 1'b0;
    xerr_nxt_rd = 1'b0;
    xr_used    = 2'h0;
    ins = 32'h0; base = 32'h0; off = 32'h0; sum = 32'h0;
    u = 3'h0; side = 1'b0; ex = 1'b0; sz = 2'h0;
    for (int i = 0; i < fetch_dispatch_pkg::SLOTS; i++) begin
      if (grp_mask[i]) begin
        ins  = pkt_r[i*32 +: 32];
        u    = ins[fetch_dispatch_pkg::UNIT_LSB +: 3];
        side = u[2];
        if (valid_nxt[u]) begin
          clash_nxt = 1'b1;
        end else begin
          valid_nxt[u]       = 1'b1;
          instr_nxt[u*32 +: 32] = ins;
          opb_nxt[u*32 +: 32]   = rf_r[{side, ins[fetch_dispatch_pkg::SRC2_LSB +: 4]}];
          if (ins[fetch_dispatch_pkg::XPATH_BIT]) begin
            if (xr_used[side]) begin
              xerr_nxt_rd = 1'b1;
              opa_nxt[u*32 +: 32] = 32'h0;
            end else begin
              xr_used[side] = 1'b1;
              opa_nxt[u*32 +: 32] = rf_r[{~side, ins[fetch_dispatch_pkg::SRC1_LSB +: 4]}];
            end
          end else begin
            opa_nxt[u*32 +: 32] = rf_r[{side, ins[fetch_dispatch_pkg::SRC1_LSB +: 4]}];
          end
          if (ins[fetch_dispatch_pkg::CREG_LSB +: 3] == 3'h0) begin
            ex = 1'b1;
          end else begin
            ex = ((rf_r[cond_reg(ins[fetch_dispatch_pkg::CREG_LSB +: 3])] == 32'h0) == ins[fetch_dispatch_pkg::Z_BIT]);
          end
          if (ins[fetch_dispatch_pkg::MEM_BIT]) begin
            if (u[1:0] != fetch_dispatch_pkg::U_ADDR) begin
              ill_nxt = 1'b1;
              ex      = 1'b0;
            end else begin
              if (ins[fetch_dispatch_pkg::LONG_BIT]) begin
                sz   = fetch_dispatch_pkg::SZ_WORD;
                base = rf_r[{side, fetch_dispatch_pkg::LONG_BASE_REG}];
                off  = {17'h0, ins[fetch_dispatch_pkg::LONG_OFF_LSB +: 15]};
              end else begin
                sz   = ins[fetch_dispatch_pkg::SIZE_LSB +: 2];
                base = rf_r[{side, ins[fetch_dispatch_pkg::SRC2_LSB +: 4]}];
                off  = {27'h0, ins[fetch_dispatch_pkg::SRC1_LSB +: 5]};
              end
              sum = base + (off << sz);
              if (ins[fetch_dispatch_pkg::CIRC_BIT] && !ins[fetch_dispatch_pkg::LONG_BIT]) begin
                sum = {base[31:CIRC_BITS], sum[CIRC_BITS-1:0]};
              end
              mreq_nxt[side]          = ex;
              mwe_nxt[side]           = ex && ins[fetch_dispatch_pkg::STORE_BIT];
              msize_nxt[side*2 +: 2]  = sz;
              maddr_nxt[side*32 +: 32] = sum;
              mwdata_nxt[side*32 +: 32] = fmt_store(rf_r[ins[fetch_dispatch_pkg::DST_LSB +: 5]], sz);
            end
          end
          exec_nxt[u] = ex;
        end
      end
    end
  end

  // ==========================================================================
  // register file writeback, cross writes limited per side
  always_comb begin
    for (int r = 0; r < fetch_dispatch_pkg::RF_ALL; r++) begin
      rf_nxt[r] = rf_r[r];
    end
    xw_used     = 2'h0;
    xerr_nxt_wr = 1'b0;
    wdst        = 5'h0;
    wb_word     = 32'h0;
    for (int k = 0; k < fetch_dispatch_pkg::UNITS; k++) begin
      if (i_wb_en[k]) begin
        wdst    = i_wb_dst[k*5 +: 5];
        wb_word = i_wb_data[k*32 +: 32];
        if (wdst[4] != k[2]) begin
          if (xw_used[k[2]]) begin
            xerr_nxt_wr = 1'b1;
          end else begin
            xw_used[k[2]] = 1'b1;
            rf_nxt[wdst]  = wb_word;
          end
        end else begin
          rf_nxt[wdst] = wb_word;
        end
      end
    end
  end
  assign xerr_nxt = xerr_nxt_rd | xerr_nxt_wr;

  // ==========================================================================
  // registers
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_r  <= fetch_dispatch_pkg::ST_WAIT;
      pc_r     <= fetch_dispatch_pkg::FETCH_RESET_ADDR;
      pkt_r    <= '0;
      ptr_r    <= 3'h0;
      req_r    <= 1'b0;
      valid_r  <= 8'h00;
      exec_r   <= 8'h00;
      instr_r  <= '0;
      opa_r    <= '0;
      opb_r    <= '0;
      mreq_r   <= 2'h0;
      mwe_r    <= 2'h0;
      msize_r  <= 4'h0;
      maddr_r  <= '0;
      mwdata_r <= '0;
      clash_r  <= 1'b0;
      xerr_r   <= 1'b0;
      ill_r    <= 1'b0;
      for (int r = 0; r < fetch_dispatch_pkg::RF_ALL; r++) begin
        rf_r[r] <= 32'h0;
      end
    end else begin
      state_r  <= state_nxt;
      pc_r     <= pc_nxt;
      pkt_r    <= pkt_nxt;
      ptr_r    <= ptr_nxt;
      req_r    <= req_nxt;
      valid_r  <= valid_nxt;
      exec_r   <= exec_nxt;
      instr_r  <= instr_nxt;
      opa_r    <= opa_nxt;
      opb_r    <= opb_nxt;
      mreq_r   <= mreq_nxt;
      mwe_r    <= mwe_nxt;
      msize_r  <= msize_nxt;
      maddr_r  <= maddr_nxt;
      mwdata_r <= mwdata_nxt;
      clash_r  <= clash_nxt;
      xerr_r   <= xerr_nxt;
      ill_r    <= ill_nxt;
      for (int r = 0; r < fetch_dispatch_pkg::RF_ALL; r++) begin
        rf_r[r] <= rf_nxt[r];
      end
    end
  end

  assign o_fetch_req  = req_r;
  assign o_fetch_addr = pc_r;
  assign o_unit_valid = valid_r;
  assign o_unit_exec  = exec_r;
  assign o_unit_instr = instr_r;
  assign o_unit_opa   = opa_r;
  assign o_unit_opb   = opb_r;
  assign o_mem_req    = mreq_r;
  assign o_mem_we     = mwe_r;
  assign o_mem_size   = msize_r;
  assign o_mem_addr   = maddr_r;
  assign o_mem_wdata  = mwdata_r;
  assign o_unit_clash = clash_r;
  assign o_xpath_err  = xerr_r;
  assign o_illegal    = ill_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  chk_no_fetch_disp: assert property (!(req_r && state_r == fetch_dispatch_pkg::ST_DISP))
    else $error("fetch requested while dispatching");
  chk_fetch_step: assert property (req_r && i_fetch_valid && state_r == fetch_dispatch_pkg::ST_WAIT
    |=> pc_r == $past(pc_r) + 32'h20 && state_r == fetch_dispatch_pkg::ST_DISP && ptr_r == 3'h0)
    else $error("fetch packet not taken correctly");
  chk_slot7_close: assert property (grp_mask[7] |=> state_r == fetch_dispatch_pkg::ST_WAIT ##1 req_r)
    else $error("last slot did not end the fetch packet");
  chk_disp_bound: assert property ($rose(state_r == fetch_dispatch_pkg::ST_DISP)
    |-> ##[1:8] state_r == fetch_dispatch_pkg::ST_WAIT)
    else $error("more than eight packets from one fetch packet");
  chk_issue_count: assert property (state_r == fetch_dispatch_pkg::ST_DISP && !clash_nxt
    |=> $countones(valid_r) == $countones($past(grp_mask)))
    else $error("issued unit count differs from packet size");
  chk_idle_units: assert property (state_r == fetch_dispatch_pkg::ST_WAIT |=> valid_r == 8'h00)
    else $error("unit issued without a packet");
  chk_exec_valid: assert property ((exec_r & ~valid_r) == 8'h00)
    else $error("execute without issue");
  chk_byte_store: assert property (mwe_r[0] && msize_r[1:0] == fetch_dispatch_pkg::SZ_BYTE
    |-> mwdata_r[31:24] == mwdata_r[7:0] && mwdata_r[15:8] == mwdata_r[7:0])
    else $error("byte store not replicated");
  chk_mem_addr_unit: assert property (mreq_r[0] |-> valid_r[3] && exec_r[3])
    else $error("memory access not from address unit");

  for (genvar g = 0; g < 7; g++) begin : g_chain
    chk_chain_link: assert property (grp_mask[g] && pkt_r[g*32] |-> grp_mask[g+1])
      else $error("chained slot left out of packet");
    chk_chain_break: assert property (grp_mask[g] && !pkt_r[g*32] |-> !grp_mask[g+1])
      else $error("packet ran past a chain break");
  end
endmodule : vliw_fetch_packet_dispatch

// ===== verification/prog_mem_model.sv
// program memory partner: answers a held fetch request with a one-cycle valid strobe
// assumes the bench supplies the packet and the answer delay in cycles (1 or more)
`timescale 1ns/10ps
module prog_mem_model (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  // fetch side
  input  wire logic         i_fetch_req,
  input  wire logic [3:0]   i_delay,
  input  wire logic [255:0] i_pkt,
  output logic              o_fetch_valid,
  output logic [255:0]      o_fetch_data
);
  int cnt;
  initial begin
    o_fetch_valid = 1'b0;
    o_fetch_data  = '0;
    cnt           = 0;
  end
  // ==========================================================================
  // answer, driven just after the edge
  always @(posedge i_mclk) begin
    #1;
    if (!i_rstn) begin
      o_fetch_valid = 1'b0;
      cnt           = 0;
    end else if (o_fetch_valid) begin
      o_fetch_valid = 1'b0;
      o_fetch_data  = ~o_fetch_data;
      cnt           = 0;
    end else if (i_fetch_req) begin
      if (cnt >= int'(i_delay)) begin
        o_fetch_valid = 1'b1;
        o_fetch_data  = i_pkt;
      end else begin
        cnt++;
      end
    end
  end
endmodule : prog_mem_model

// ===== verification/tb_top.sv
// bench for the fetch and dispatch front end
// assumes program memory partner model and no writeback traffic
`timescale 1ns/10ps
module tb_top;
  logic          i_mclk;
  logic          i_rstn;
  logic          o_fetch_req;
  logic [31:0]   o_fetch_addr;
  logic          o_fetch_valid;
  logic [255:0]  o_fetch_data;
  logic [7:0]    o_unit_valid;
  logic [7:0]    o_unit_exec;
  logic [255:0]  o_unit_instr;
  logic          o_unit_clash;
  logic [255:0]  mem_pkt;
  logic [3:0]    mem_dly;
  logic [7:0]    got_m [16];
  logic [7:0]    exp_m [8];
  logic [255:0]  got_instr;
  logic [31:0]   addr_seen;
  logic [31:0]   next_addr;
  logic          clash_seen;
  logic          exec_ok;
  int            n_got;
  int            n_exp;
  int            bad_count;
  int            check_count;
  int            cycles;
  // ==========================================================================
  // clock, reset, timeout
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles >= 5000) begin
      bad_count++;
      finish_test();
    end
  end
  // ==========================================================================
  // design and partner
  vliw_fetch_packet_dispatch dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
    .i_fetch_valid(o_fetch_valid), .i_fetch_data(o_fetch_data), .o_unit_valid(o_unit_valid),
    .o_unit_exec(o_unit_exec), .o_unit_instr(o_unit_instr), .o_unit_opa(), .o_unit_opb(),
    .i_wb_en(8'h00), .i_wb_dst(40'h0), .i_wb_data(256'h0), .o_mem_req(), .o_mem_we(),
    .o_mem_size(), .o_mem_addr(), .o_mem_wdata(), .o_unit_clash(o_unit_clash), .o_xpath_err(),
    .o_illegal()
  );
  prog_mem_model mem (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_fetch_req(o_fetch_req), .i_delay(mem_dly),
    .i_pkt(mem_pkt), .o_fetch_valid(o_fetch_valid), .o_fetch_data(o_fetch_data)
  );
  // ==========================================================================
  // helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic check_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check_vec
  // slot i: dst field = i, unit from units, chain from chain
  function automatic logic [255:0] build(input logic [23:0] units, input logic [7:0] chain);
    logic [255:0] p;
    p = '0;
    for (int i = 0; i < 8; i++) begin
      p[32*i +: 32] = (32'(i) << 23) | (32'(units[3*i +: 3]) << 2) | 32'(chain[i]);
    end
    return p;
  endfunction : build
  // serve one packet, collect issued unit masks until the next request
  task automatic run_pkt(input logic [255:0] pkt, input logic [3:0] dly);
    logic [7:0] m;
    m     = 8'h00;
    n_exp = 0;
    for (int i = 0; i < 8; i++) begin
      m = m | (8'h01 << pkt[32*i+2 +: 3]);
      if (pkt[32*i] == 1'b0 || i == 7) begin
        exp_m[n_exp] = m;
        n_exp++;
        m = 8'h00;
      end
    end
    mem_pkt    = pkt;
    mem_dly    = dly;
    clash_seen = 1'b0;
    exec_ok    = 1'b1;
    n_got      = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge i_mclk);
      #2;
      if (o_fetch_valid === 1'b1 && o_fetch_req === 1'b1) break;
    end
    addr_seen = o_fetch_addr;
    @(posedge i_mclk);
    for (int i = 0; i < 16; i++) begin
      @(posedge i_mclk);
      #2;
      if (o_unit_clash === 1'b1) clash_seen = 1'b1;
      if (o_unit_valid !== 8'h00) begin
        if (n_got == 0) got_instr = o_unit_instr;
        if (o_unit_exec !== o_unit_valid) exec_ok = 1'b0;
        got_m[n_got] = o_unit_valid;
        n_got++;
      end
      if (o_fetch_req === 1'b1) break;
    end
    check_vec("fetch addr", next_addr, addr_seen);
    next_addr = next_addr + fetch_dispatch_pkg::FETCH_STEP;
  endtask : run_pkt
  task automatic check_masks();
    check_vec("packet count", 32'(n_exp), 32'(n_got));
    for (int i = 0; i < n_exp && i < n_got; i++) begin
      check_vec("unit mask", 32'(exp_m[i]), 32'(got_m[i]));
    end
    check_vec("exec mask", 32'h1, 32'(exec_ok));
  endtask : check_masks
  // ==========================================================================
  // scenarios
  task automatic t_chained();
    run_pkt(build(24'hfac688, 8'hff), 4'h1);
    check_masks();
    for (int u = 0; u < 8; u++) begin
      check_vec("unit instr", (32'(u) << 23) | (32'(u) << 2) | 32'h1, got_instr[32*u +: 32]);
    end
    $display("test chained done");
  endtask : t_chained
  task automatic t_single();
    run_pkt(build(24'hfac688, 8'h00), 4'h4);
    check_masks();
    $display("test single done");
  endtask : t_single
  task automatic t_mixed();
    run_pkt(build(24'h053977, 8'hcd), 4'h1);
    check_masks();
    $display("test mixed done");
  endtask : t_mixed
  task automatic t_clash();
    run_pkt(build(24'hfac692, 8'h01), 4'h2);
    check_masks();
    check_vec("unit clash", 32'h1, 32'(clash_seen));
    $display("test clash done");
  endtask : t_clash
  // ==========================================================================
  // main sequence
  initial begin
    i_rstn      = 1'b0;
    mem_pkt     = '0;
    mem_dly     = 4'h1;
    bad_count   = 0;
    check_count = 0;
    cycles      = 0;
    next_addr   = fetch_dispatch_pkg::FETCH_RESET_ADDR;
    repeat (10) @(posedge i_mclk);
    #1;
    i_rstn = 1'b1;
    t_chained();
    t_single();
    t_mixed();
    t_clash();
    t_chained();
    finish_test();
  end
endmodule : tb_top
